// File: rma_pkg.sv
package rma_pkg;

  // A16 geometry: register-based modules live in the upper quarter.
  localparam logic [15:0] REGION_BASE = 16'hc000;
  localparam int BLOCK_SHIFT = 6;
  localparam logic [7:0] LOGICAL_ADDRESS_DEFAULT = 8'h78;

  // Offsets inside the 64-byte block.
  localparam logic [5:0] OFS_MFR_ID = 6'h00;
  localparam logic [5:0] OFS_DEV_TYPE = 6'h02;
  localparam logic [5:0] OFS_STATUS_CONTROL = 6'h04;
  localparam logic [5:0] OFS_RELAY_FIRST = 6'h20;

  // Fixed read values; the identity codes are arbitrary.
  localparam logic [15:0] MFR_ID_VALUE = 16'hfffe;
  localparam logic [15:0] DEV_TYPE_VALUE = 16'h0001;
  localparam logic [15:0] RELAY_READ_VALUE = 16'hffff;
  localparam logic [15:0] UNMAPPED_READ_VALUE = 16'hffff;

  // Status/control field positions.
  localparam int SC_BIT_SOFT_RESET = 0;
  localparam int SC_BIT_IRQ_DISABLE = 6;
  localparam int SC_BIT_NOT_BUSY = 7;
  localparam int SC_BIT_NOT_SELECTED = 14;
  localparam int SC_MODID_LSB = 10;
  localparam logic [15:0] SC_FIXED_ONES = 16'h800c;
  localparam logic [3:0] MODULE_ID_DEFAULT = 4'h6;

  localparam int NUM_BANKS = 16;

  // Relay settle time: 7 ms at 20 MHz.
  localparam int CLK_HZ = 20000000;
  localparam int RELAY_SETTLE_US = 7000;
  localparam int RELAY_SETTLE_CYCLES = CLK_HZ / 1000000 * RELAY_SETTLE_US;

  // One bus access.
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rma_req_t;

  typedef enum logic [0:0] {
    RMA_IDLE = 1'b0,
    RMA_BUSY = 1'b1
  } rma_busy_state_t;

endpackage

// File: rma_busy_timer.sv
`timescale 1ns/1ps
module rma_busy_timer #(
  parameter int SETTLE_CYCLES = rma_pkg::RELAY_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic busy
);

  rma_pkg::rma_busy_state_t state;
  rma_pkg::rma_busy_state_t next_state;
  logic [17:0] count;
  logic [17:0] next_count;

  // A new relay write restarts the full settle time.
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      rma_pkg::RMA_IDLE: begin
        if (start) begin
          next_state = rma_pkg::RMA_BUSY;
          next_count = 18'(SETTLE_CYCLES - 1);
        end
      end
      rma_pkg::RMA_BUSY: begin
        if (start) begin
          next_count = 18'(SETTLE_CYCLES - 1);
        end else if (count == 18'h0) begin
          next_state = rma_pkg::RMA_IDLE;
        end else begin
          next_count = count - 18'h1;
        end
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= rma_pkg::RMA_IDLE;
      count <= 18'h0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign busy = (state == rma_pkg::RMA_BUSY);

endmodule

// File: rma_regs.sv
`timescale 1ns/1ps
module rma_regs #(
  parameter int SETTLE_CYCLES = rma_pkg::RELAY_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input rma_pkg::rma_req_t req,
  input wire logic address_load,
  input wire logic [7:0] logical_address_setting,
  input wire logic [3:0] module_id,
  input wire logic modid_selected,
  output logic ack,
  output logic [15:0] rdata,
  output logic [255:0] relay_close,
  output logic irq_disable,
  output logic soft_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [7:0] logical_address;
  logic [7:0] next_logical_address;
  logic [15:0] block_base;
  logic hit;
  logic [5:0] offset;
  logic busy;
  logic relay_write;
  logic [3:0] bank;

  // Base grows from the upper-quarter origin in 64-byte steps, so any
  // logical address lands in C000..FFFF.
  assign block_base = rma_pkg::REGION_BASE
      + {2'h0, logical_address, 6'h0};
  // Only even word addresses within the block are taken.
  assign hit = req.valid
      && (req.addr[15:rma_pkg::BLOCK_SHIFT]
          == block_base[15:rma_pkg::BLOCK_SHIFT])
      && !req.addr[0];
  assign offset = req.addr[5:0] - block_base[5:0];
  assign relay_write = hit && req.write
      && (offset >= rma_pkg::OFS_RELAY_FIRST);
  assign bank = offset[4:1];

  ////////////////////////////////////////////////////////////////////////////
  // Logical address setting.

  // Delivered default, reloadable from the configuration input.
  always_comb begin
    next_logical_address = logical_address;
    if (address_load) begin
      next_logical_address = logical_address_setting;
    end
  end

  // Register for the setting.
  always_ff @(posedge clk) begin
    if (reset) begin
      logical_address <= rma_pkg::LOGICAL_ADDRESS_DEFAULT;
    end else begin
      logical_address <= next_logical_address;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits and relay banks.

  logic next_irq_disable;
  logic next_soft_reset;
  logic [255:0] next_relay_close;

  // Status/control writes touch only bits 0 and 6.
  always_comb begin
    next_irq_disable = irq_disable;
    next_soft_reset = soft_reset;
    if (hit && req.write && offset == rma_pkg::OFS_STATUS_CONTROL) begin
      next_irq_disable = req.wdata[rma_pkg::SC_BIT_IRQ_DISABLE];
      next_soft_reset = req.wdata[rma_pkg::SC_BIT_SOFT_RESET];
    end
  end

  // One generate entry per bank; ID register writes fall through
  // with no effect.
  genvar gi;
  generate
    for (gi = 0; gi < rma_pkg::NUM_BANKS; gi++) begin : g_bank
      always_comb begin
        next_relay_close[gi*16 +: 16] = relay_close[gi*16 +: 16];
        if (relay_write && bank == 4'(gi)) begin
          next_relay_close[gi*16 +: 16] = req.wdata;
        end
      end
    end
  endgenerate

  // Control registers; reset opens all relays.
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_disable <= 1'b0;
      soft_reset <= 1'b0;
      relay_close <= '0;
    end else begin
      irq_disable <= next_irq_disable;
      soft_reset <= next_soft_reset;
      relay_close <= next_relay_close;
    end
  end

  // Each relay write starts the settle timer.
  rma_busy_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_busy (
    .clk(clk),
    .reset(reset),
    .start(relay_write),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic next_ack;
  logic [15:0] next_rdata;
  logic [15:0] status_word;

  // Fixed ones at bits 15, 9..8 and 5..0; busy is reported active low.
  always_comb begin
    status_word = rma_pkg::SC_FIXED_ONES;
    status_word[rma_pkg::SC_MODID_LSB +: 4] = module_id;
    status_word[rma_pkg::SC_BIT_NOT_SELECTED] = !modid_selected;
    status_word[rma_pkg::SC_BIT_NOT_BUSY] = !busy;
    status_word[rma_pkg::SC_BIT_IRQ_DISABLE] = irq_disable;
    status_word[9:8] = 2'h3;
    status_word[5:4] = 2'h3;
    status_word[1:0] = 2'h3;
  end

  // Ack one cycle after any hit; misses never ack.
  always_comb begin
    next_ack = hit;
    next_rdata = rdata;
    if (hit && !req.write) begin
      if (offset == rma_pkg::OFS_MFR_ID) begin
        next_rdata = rma_pkg::MFR_ID_VALUE;
      end else if (offset == rma_pkg::OFS_DEV_TYPE) begin
        next_rdata = rma_pkg::DEV_TYPE_VALUE;
      end else if (offset == rma_pkg::OFS_STATUS_CONTROL) begin
        next_rdata = status_word;
      end else if (offset >= rma_pkg::OFS_RELAY_FIRST) begin
        next_rdata = rma_pkg::RELAY_READ_VALUE;
      end else begin
        next_rdata = rma_pkg::UNMAPPED_READ_VALUE;
      end
    end
  end

  // Answer registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
      rdata <= 16'h0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

endmodule

// File: rma_regs_chk.sv
`timescale 1ns/1ps
module rma_regs_chk (
  input wire logic clk,
  input wire logic reset,
  input rma_pkg::rma_req_t req,
  input wire logic address_load,
  input wire logic [7:0] logical_address_setting,
  input wire logic [3:0] module_id,
  input wire logic modid_selected,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic [255:0] relay_close,
  input wire logic irq_disable,
  input wire logic soft_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [15:0] base, next_base;
  logic [5:0] ofs;
  logic hit, rd;
  // Shadow base, so that the hit below follows a relocation.
  always_comb next_base = reset ? 16'hde00 : address_load ?
    16'hc000 + {logical_address_setting, 6'h0} : base;
  always_ff @(posedge clk) base <= next_base;
  // A hit is a word access inside the 64-byte block.
  assign ofs = req.addr[5:0];
  assign hit = req.valid && req.addr[15:6] == base[15:6] && !req.addr[0];
  assign rd = hit && !req.write;
  sequence relay_wr;
    hit && req.write && ofs[5];
  endsequence
  sequence status_rd;
    rd && ofs == 6'h04;
  endsequence
  ////////////////////////////////////////
  hit_ack_a: assert property (hit |=> ack)
    else $error("block access not acknowledged");
  miss_quiet_a: assert property (!hit |=> !ack)
    else $error("foreign access acknowledged");
  id_read_a: assert property (rd && ofs[5:2] == 4'h0 |=>
    rdata == ($past(ofs[1]) ? rma_pkg::DEV_TYPE_VALUE :
    rma_pkg::MFR_ID_VALUE)) else $error("identity read wrong");
  relay_ones_a: assert property (
    rd && ofs[5] |=> rdata == 16'hffff) else $error("relay read not ones");
  relay_load_a: assert property (relay_wr |=>
    relay_close[$past(ofs[4:1]) * 16 +: 16] == $past(req.wdata))
    else $error("relay bank not loaded");
  status_read_a: assert property (status_rd |=>
    rdata[14:10] == {~$past(modid_selected), $past(module_id)} &&
    rdata[6] == $past(irq_disable)) else $error("status read wrong");
  ctrl_write_a: assert property (hit && req.write && ofs == 6'h04 |=>
    {irq_disable, soft_reset} == {$past(req.wdata[6]), $past(req.wdata[0])})
    else $error("control write lost");
  busy_flag_a: assert property (
    relay_wr ##[2:8] status_rd |=> !rdata[7]) else $error("busy not shown");
endmodule

bind rma_regs rma_regs_chk rma_regs_chk_inst (.clk(clk), .reset(reset),
  .req(req), .address_load(address_load), .module_id(module_id),
  .logical_address_setting(logical_address_setting), .ack(ack),
  .modid_selected(modid_selected), .rdata(rdata), .soft_reset(soft_reset),
  .relay_close(relay_close), .irq_disable(irq_disable));

// File: rma_ctl_model.sv
`timescale 1ns/1ps
// Controller side: one-cycle word requests, slow or prompt by gap.
module rma_ctl_model (
  input wire logic clk,
  output rma_pkg::rma_req_t req
);
  logic [15:0] base = 16'hde00;
  task automatic xfer(input logic wr, input logic [15:0] ofs,
    input logic [15:0] d, input int gap);
    repeat (gap + 1) @(posedge clk);
    req <= '{1'b1, wr, base + ofs, d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  initial req = '0;
endmodule

// File: relay_matrix_a16_register_decode_test.sv
`timescale 1ns/1ps
module relay_matrix_a16_register_decode_test;
  logic clk, reset, address_load, modid_selected, irq_m;
  logic ack, irq_disable, soft_reset;
  logic [7:0] la;
  logic [3:0] module_id;
  logic [15:0] rdata;
  logic [15:0] bad [3] = '{16'h21, 16'h60, 16'hffe0};
  logic [255:0] relay_close;
  logic [31:0] seed = 32'h5da1;
  rma_pkg::rma_req_t req;
  int fail_count = 0;
  int total_checks = 0;
  int relay_m [16];
  rma_regs #(.SETTLE_CYCLES(20)) rma_regs_inst (.clk(clk), .reset(reset),
    .req(req), .address_load(address_load), .logical_address_setting(la),
    .module_id(module_id), .modid_selected(modid_selected), .ack(ack),
    .rdata(rdata), .relay_close(relay_close), .irq_disable(irq_disable),
    .soft_reset(soft_reset));
  rma_ctl_model rma_ctl_model_inst (.clk(clk), .req(req));
  ////////////////////////////////////////
  // Clock, xorshift source, compare and closing tasks.
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [15:0] o, e);
    rma_ctl_model_inst.xfer(1'b0, o, 16'h0, rnd() % 4);
    chk("ack", {15'h0, ack}, 16'h1);
    chk("rdata", rdata, e);
  endtask
  task automatic wr(input logic [15:0] o, d);
    rma_ctl_model_inst.xfer(1'b1, o, d, rnd() % 4);
    chk("ack", {15'h0, ack}, 16'h1);
  endtask
  // Unlisted status bits read as ones; busy is bit 7 low.
  function automatic logic [15:0] sc(input logic nb);
    return {1'b1, ~modid_selected, module_id, 2'b11, nb, irq_m, 6'h3f};
  endfunction
  ////////////////////////////////////////
  initial begin
    reset = 1;
    address_load = 0;
    la = 8'h0;
    irq_m = 0;
    module_id = 4'(rnd());
    modid_selected = seed[0];
    repeat (2) @(posedge clk);
    reset <= 0;
    wr(16'h0, 16'h1234);
    wr(16'h2, 16'h1234);
    rd(16'h0, rma_pkg::MFR_ID_VALUE);
    rd(16'h2, rma_pkg::DEV_TYPE_VALUE);
    for (int b = 0; b < 16; b++) begin
      relay_m[b] = int'(rnd() & 32'hffff);
      wr(16'(32 + 2 * b), 16'(relay_m[b]));
      rd(16'h4, sc(1'b0));
      rd(16'(32 + 2 * b), 16'hffff);
    end
    for (int b = 0; b < 16; b++)
      chk("bank", relay_close[b * 16 +: 16], 16'(relay_m[b]));
    irq_m = 1;
    wr(16'h4, 16'h0041);
    repeat (30) @(posedge clk);
    rd(16'h4, sc(1'b1));
    chk("ctrl", {14'h0, irq_disable, soft_reset}, 16'h3);
    $display("register test done");
    // Odd, next-block and previous-block writes must be ignored.
    foreach (bad[i]) begin
      rma_ctl_model_inst.xfer(1'b1, bad[i], 16'hffff, 0);
      chk("miss", {15'h0, ack}, 16'h0);
    end
    chk("bank0", relay_close[15:0], 16'(relay_m[0]));
    $display("decode test done");
    @(posedge clk);
    la <= 8'(rnd());
    address_load <= 1;
    @(posedge clk);
    address_load <= 0;
    rma_ctl_model_inst.base = 16'hc000 + {la, 6'h0};
    rd(16'h2, rma_pkg::DEV_TYPE_VALUE);
    $display("relocation test done");
    conclude();
  end
  // Watchdog: the run needs well under 2000 cycles.
  initial begin
    #100us;
    fail_count++;
    conclude();
  end
endmodule
